// File: design/toefq_top.sv
// timed output event fifo: image intake, sequence check, queue, release
// Notes on behaviour
// - output image holds 5 entries (20 bytes) or 15 entries (60 bytes).
// - queue holds at most 31 entries whatever the image size.
// - a full queue refuses further entries and does not store them.
// - status image: last sequence, next sequence, queue state, fill count.
// - status byte 0: last stored sequence, bit 6 one, bit 7 zero.
// - status byte 1: next sequence to execute, bits 6 and 7 one.
// - queue state codes: 0 stored, 1 bad sequence, 2 nothing new, 3 full.
// - while a queued entry has the end marker, queue state has 80h ored.
// - status byte 3 always shows the current queue fill count.
// - entry is pattern, sequence, 16-bit time, packed at 4-byte strides.
// - pattern bits 3..0 zero; bits 7,6,5,4 drive channels 0,1,2,3.
// - sequence runs 0..63 from 1; only the expected increment is accepted.
// - end marker bit 6 on a sequence makes all later entries of that image ignored.
// - 32-bit microsecond counter runs from power-on and wraps to zero.
// - entry time matches counter low word; pattern is applied then.
`timescale 1ns/100ps
`include "toefq_cfg.svh"
module toefq_top #(
    parameter int QDEPTH    = `TOEFQ_QDEPTH,
    parameter int US_CYCLES = `TOEFQ_US_CYCLES
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // configuration
    input  wire logic       cfg_wide_i,
    // output image write
    input  wire logic       img_we_i,
    input  wire logic [5:0] img_addr_i,
    input  wire logic [7:0] img_data_i,
    input  wire logic       img_commit_i,
    output logic            img_busy_o,
    // status image
    output logic [7:0]      stat_last_o,
    output logic [7:0]      stat_next_o,
    output logic [7:0]      stat_queue_o,
    output logic [7:0]      stat_fill_o,
    // channel outputs
    output logic [3:0]      do_o
);
    import toefq_pkg::*;

    localparam int PW = $clog2(QDEPTH);

    logic [7:0]          img_q [64];
    toefq_entry_s        mem_q [QDEPTH];
    toefq_state_e        state_q;
    logic [3:0]          slot_q;
    logic [5:0]          last_q;
    logic [1:0]          code_q;
    logic                acc_q;
    logic                bad_q;
    logic [PW-1:0]       wr_q;
    logic [PW-1:0]       rd_q;
    logic [5:0]          count_q;
    logic [5:0]          endc_q;
    logic [6:0]          pre_q;
    logic [31:0]         us_q;
    logic                tick;
    logic [7:0]          e_pat;
    logic [7:0]          e_seq;
    logic [15:0]         e_tim;
    logic [3:0]          nslots;
    logic                scan;
    logic                seq_ok;
    logic                full;
    logic                push;
    logic                pop;
    logic                last_slot;
    toefq_entry_s        head;
    toefq_entry_s        new_e;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // image buffer: locked while a scan reads it
    always_ff @(posedge clk_sys_i) begin
        if (img_we_i && state_q == TOEFQ_IDLE) begin
            img_q[img_addr_i] <= img_data_i;
        end
    end

    assign nslots = cfg_wide_i ? `TOEFQ_SLOTS_LARGE
                               : `TOEFQ_SLOTS_SMALL;
    assign scan   = (state_q == TOEFQ_SCAN);
    assign e_pat  = img_q[{slot_q, `TOEFQ_OFF_PAT}];
    assign e_seq  = img_q[{slot_q, `TOEFQ_OFF_SEQ}];
    assign e_tim  = {img_q[{slot_q, `TOEFQ_OFF_TIME_HI}],
                     img_q[{slot_q, `TOEFQ_OFF_TIME_LO}]};
    assign seq_ok = (e_seq[5:0] == 6'(last_q + 6'h01));
    assign full   = (count_q == 6'(QDEPTH));
    assign push   = scan && seq_ok && !full;
    assign last_slot = (slot_q >= 4'(nslots - 4'h1));
    assign head   = mem_q[rd_q];
    assign pop    = (count_q != 6'h00)
                    && (us_q[15:0] == head.tim);
    // pattern bit 7 belongs to channel 0, bit 4 to channel 3
    assign new_e  = '{pat: {e_pat[4], e_pat[5], e_pat[6], e_pat[7]},
                      end_f: e_seq[`TOEFQ_SEQ_END_BIT],
                      seq: e_seq[5:0], tim: e_tim};

    // microsecond ticker from the system clock
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q <= 7'h00;
        end else if (tick) begin
            pre_q <= 7'h00;
        end else begin
            pre_q <= pre_q + 7'h01;
        end
    end
    assign tick = (pre_q == 7'(US_CYCLES - 1));

    // natural 32-bit wrap
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            us_q <= 32'h0000_0000;
        end else if (tick) begin
            us_q <= us_q + 32'h0000_0001;
        end
    end

    // scan sequencer: one image slot per cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= TOEFQ_IDLE;
            slot_q  <= 4'h0;
            acc_q   <= 1'b0;
            bad_q   <= 1'b0;
        end else begin
            unique case (state_q)
                TOEFQ_IDLE: begin
                    slot_q <= 4'h0;
                    acc_q  <= 1'b0;
                    bad_q  <= 1'b0;
                    if (img_commit_i) begin
                        state_q <= TOEFQ_SCAN;
                    end
                end
                TOEFQ_SCAN: begin
                    acc_q  <= acc_q | push;
                    bad_q  <= bad_q | !seq_ok;
                    slot_q <= slot_q + 4'h1;
                    // full-queue refusal ends the scan; end marker hides the rest
                    if ((seq_ok && full) || last_slot
                        || e_seq[`TOEFQ_SEQ_END_BIT]) begin
                        state_q <= TOEFQ_DONE;
                    end
                end
                TOEFQ_DONE: begin
                    state_q <= TOEFQ_IDLE;
                end
                default: begin
                    state_q <= TOEFQ_IDLE;
                end
            endcase
        end
    end

    // last accepted sequence
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_q <= `TOEFQ_SEQ_RESET;
        end else if (push) begin
            last_q <= e_seq[5:0];
        end
    end

    // queue state code
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_q <= `TOEFQ_ST_NONEW;
        end else if (scan && seq_ok && full) begin
            code_q <= `TOEFQ_ST_FULL;
        end else if (state_q == TOEFQ_DONE && code_q != `TOEFQ_ST_FULL)
        begin
            if (acc_q) begin
                code_q <= `TOEFQ_ST_OK;
            end else if (bad_q) begin
                code_q <= `TOEFQ_ST_NOFOLLOW;
            end else begin
                code_q <= `TOEFQ_ST_NONEW;
            end
        end else if (state_q == TOEFQ_IDLE && img_commit_i) begin
            code_q <= `TOEFQ_ST_NONEW;
        end else if (pop && count_q == 6'h01 && !scan) begin
            // drained: nothing follows the executed entry
            code_q <= `TOEFQ_ST_NOFOLLOW;
        end
    end

    // queue storage
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_q] <= new_e;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(QDEPTH - 1)) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(QDEPTH - 1)) ? '0 : rd_q + PW'(1);
            end
        end
    end

    // fill and end-marker counts
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= 6'h00;
            endc_q  <= 6'h00;
        end else begin
            count_q <= count_q + 6'(push) - 6'(pop);
            endc_q  <= endc_q + 6'(push && new_e.end_f)
                       - 6'(pop && head.end_f);
        end
    end

    // channel outputs take the head pattern at its time
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            do_o <= 4'h0;
        end else if (pop) begin
            do_o <= head.pat;
        end
    end

    // status image, registered; next holds its value when empty
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_last_o  <= {`TOEFQ_LAST_FIX, `TOEFQ_SEQ_RESET};
            stat_next_o  <= {`TOEFQ_NEXT_FIX, `TOEFQ_SEQ_RESET};
            stat_queue_o <= {6'h00, `TOEFQ_ST_NONEW};
            stat_fill_o  <= 8'h00;
            img_busy_o   <= 1'b0;
        end else begin
            stat_last_o  <= {`TOEFQ_LAST_FIX, last_q};
            if (count_q != 6'h00) begin
                stat_next_o <= {`TOEFQ_NEXT_FIX, head.seq};
            end
            stat_queue_o <= {endc_q != 6'h00, 5'h00, code_q};
            stat_fill_o  <= {2'h0, count_q};
            img_busy_o   <= (state_q != TOEFQ_IDLE) || img_commit_i;
        end
    end

    sequence s_exec;
        pop ##0 (head.tim == us_q[15:0]);
    endsequence

    sequence s_scan_end;
        scan && e_seq[`TOEFQ_SEQ_END_BIT];
    endsequence

    sequence s_refuse;
        scan && seq_ok && full;
    endsequence

    // a store in the closing slot, then the wrap-up cycle
    sequence s_push_last;
        push ##1 (state_q == TOEFQ_DONE);
    endsequence

    // intake and sequence order
    a_slot_limit: assert property (scan |-> slot_q < nslots)
        else $error("scan past configured slots");
    a_end_stop: assert property (s_scan_end |=> !scan)
        else $error("entries taken after end marker");
    a_seq_order: assert property (push |->
        (e_seq[5:0] == 6'(last_q + 6'h01))
        ##2 (stat_last_o[5:0] == $past(e_seq[5:0], 2)))
        else $error("out of order entry stored");
    a_bad_keep: assert property ((scan && !seq_ok) |=>
        last_q == $past(last_q))
        else $error("refused entry moved last sequence");
    a_busy_scan: assert property ((state_q != TOEFQ_IDLE)
        |-> img_busy_o)
        else $error("image not locked during scan");

    // queue bookkeeping
    a_fill_bound: assert property (count_q <= 6'(QDEPTH))
        else $error("queue count above depth");
    a_full_refuse: assert property (s_refuse |=>
        count_q <= $past(count_q))
        else $error("entry stored into full queue");
    a_fill_push: assert property ((push && !pop) |=>
        count_q == $past(count_q) + 6'h01)
        else $error("count not raised on store");
    a_pop_count: assert property ((pop && !push) |=>
        count_q == $past(count_q) - 6'h01)
        else $error("count not reduced on execution");
    a_fifo_order: assert property ((pop && count_q > 6'h01) |=>
        head.seq == $past(head.seq) + 6'h01)
        else $error("queue left sequence order");
    a_ptr_range: assert property ((wr_q <= PW'(QDEPTH - 1))
        && (rd_q <= PW'(QDEPTH - 1)))
        else $error("queue pointer out of range");

    // execution and ticker
    a_exec_apply: assert property (s_exec |=>
        do_o == $past(head.pat))
        else $error("pattern not applied at time");
    a_do_hold: assert property (!pop |=> do_o == $past(do_o))
        else $error("outputs moved without an entry");
    a_tick_inc: assert property (tick |=>
        us_q == $past(us_q) + 32'h0000_0001)
        else $error("ticker did not advance");
    a_us_hold: assert property (!tick |=> us_q == $past(us_q))
        else $error("ticker moved between ticks");

    // status image
    a_last_fixed: assert property (stat_last_o[7:6] == 2'h1)
        else $error("last sequence fixed bits wrong");
    a_next_fixed: assert property (stat_next_o[7:6] == 2'h3)
        else $error("next sequence fixed bits wrong");
    a_next_track: assert property ((count_q != 6'h00) |=>
        stat_next_o[5:0] == $past(head.seq))
        else $error("next sequence not shown");
    a_end_flag: assert property ((endc_q != 6'h00) |=>
        stat_queue_o[7])
        else $error("end marker flag missing");
    a_end_clear: assert property ((endc_q == 6'h00) |=>
        !stat_queue_o[7])
        else $error("end marker flag without marker");
    a_end_count: assert property ((push && new_e.end_f) |=>
        endc_q != 6'h00)
        else $error("end marker not counted");
    a_queue_pad: assert property (stat_queue_o[6:2] == 5'h00)
        else $error("queue state spare bits set");
    a_full_code: assert property (s_refuse |=> ##1
        stat_queue_o[1:0] == `TOEFQ_ST_FULL)
        else $error("full queue not reported");
    a_ok_code: assert property (s_push_last |=>
        code_q == `TOEFQ_ST_OK)
        else $error("stored entries not reported");
    a_drain_code: assert property ((pop && count_q == 6'h01
        && state_q == TOEFQ_IDLE && !img_commit_i) |=>
        code_q == `TOEFQ_ST_NOFOLLOW)
        else $error("drained queue not reported");
    a_fill_track: assert property (##1
        stat_fill_o == {2'h0, $past(count_q)})
        else $error("fill count not shown");
endmodule

// File: design/toefq_cfg.svh
// constants for the timed output event fifo
`ifndef TOEFQ_CFG_SVH
`define TOEFQ_CFG_SVH
`define TOEFQ_CLK_PERIOD_NS 10
`define TOEFQ_US_NS         1000
`define TOEFQ_US_CYCLES     (`TOEFQ_US_NS / `TOEFQ_CLK_PERIOD_NS)
`define TOEFQ_SLOTS_SMALL   4'h5
`define TOEFQ_SLOTS_LARGE   4'hF
`define TOEFQ_QDEPTH        31
`define TOEFQ_OFF_PAT       2'h0
`define TOEFQ_OFF_SEQ       2'h1
`define TOEFQ_OFF_TIME_HI   2'h2
`define TOEFQ_OFF_TIME_LO   2'h3
`define TOEFQ_SEQ_END_BIT   6
`define TOEFQ_SEQ_RESET     6'h00
`define TOEFQ_ST_OK         2'h0
`define TOEFQ_ST_NOFOLLOW   2'h1
`define TOEFQ_ST_NONEW      2'h2
`define TOEFQ_ST_FULL       2'h3
`define TOEFQ_LAST_FIX      2'h1
`define TOEFQ_NEXT_FIX      2'h3
`endif

// File: design/toefq_pkg.sv
// types for the timed output event fifo
package toefq_pkg;
    typedef enum logic [2:0] {
        TOEFQ_IDLE = 3'h1,
        TOEFQ_SCAN = 3'h2,
        TOEFQ_DONE = 3'h4
    } toefq_state_e;

    typedef struct packed {
        logic [3:0]  pat;
        logic        end_f;
        logic [5:0]  seq;
        logic [15:0] tim;
    } toefq_entry_s;
endpackage

// File: test/toefq_host.sv
// host model: fills the output image and commits it whole
`timescale 1ns/100ps
module toefq_host (
    // clock and handshake
    input  wire logic       clk_i,
    input  wire logic       busy_i,
    // output image write
    output logic            img_we_o,
    output logic [5:0]      img_addr_o,
    output logic [7:0]      img_data_o,
    output logic            img_commit_o
);
    initial begin
        img_we_o     = 1'b0;
        img_addr_o   = 6'h00;
        img_data_o   = 8'h00;
        img_commit_o = 1'b0;
    end

    task automatic put_byte(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        img_we_o   = 1'b1;
        img_addr_o = a;
        img_data_o = d;
    endtask

    // odd slots carry the inverted upper nibble of the even ones
    task automatic load(input int n, input logic [5:0] seq0,
                        input logic endm, input logic [7:0] pat0,
                        input logic [15:0] t0);
        logic [7:0]  sq;
        logic [15:0] tm;
        for (int i = 0; i < n; i++) begin
            sq = {1'b0, endm && i == n - 1, 6'(seq0 + 6'(i))};
            tm = t0 + 16'(2 * i);
            put_byte(6'(4 * i), i[0] ? ~pat0 & 8'hF0 : pat0);
            put_byte(6'(4 * i + 1), sq);
            put_byte(6'(4 * i + 2), tm[15:8]);
            put_byte(6'(4 * i + 3), tm[7:0]);
        end
        @(negedge clk_i);
        img_we_o     = 1'b0;
        img_commit_o = 1'b1;
        @(negedge clk_i);
        img_commit_o = 1'b0;
        while (busy_i !== 1'b0) @(negedge clk_i);
        repeat (3) @(negedge clk_i);
    endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the timed output event fifo
`timescale 1ns/100ps
module testbench;
    localparam int US = 4;
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic        cfg_wide = 1'b0;
    logic        img_we;
    logic [5:0]  img_addr;
    logic [7:0]  img_data;
    logic        img_commit;
    logic        img_busy;
    logic [7:0]  st_last;
    logic [7:0]  st_next;
    logic [7:0]  st_queue;
    logic [7:0]  st_fill;
    logic [3:0]  do_w;
    int unsigned cyc;
    int          n_errors   = 0;
    int          n_compared = 0;
    int          n_busy     = 0;

    always #5 clk_sys = ~clk_sys;

    // busy cycles, counted where the flag has settled
    always @(negedge clk_sys)
        if (img_busy === 1'b1) n_busy <= n_busy + 1;

    // bench copy of the ticker, only used to place times ahead of now
    always @(posedge clk_sys or negedge rst_n)
        if (!rst_n) cyc <= 0;
        else cyc <= cyc + 1;

    toefq_top #(.QDEPTH(31), .US_CYCLES(US)) dut_u (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .cfg_wide_i(cfg_wide),
        .img_we_i(img_we), .img_addr_i(img_addr), .img_data_i(img_data),
        .img_commit_i(img_commit), .img_busy_o(img_busy),
        .stat_last_o(st_last), .stat_next_o(st_next),
        .stat_queue_o(st_queue), .stat_fill_o(st_fill), .do_o(do_w));

    toefq_host host_u (
        .clk_i(clk_sys), .busy_i(img_busy), .img_we_o(img_we),
        .img_addr_o(img_addr), .img_data_o(img_data),
        .img_commit_o(img_commit));

    function automatic logic [15:0] ahead(input int us);
        return 16'(cyc / US + us);
    endfunction

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stat(input logic [7:0] l, input logic [7:0] n,
                        input logic [7:0] q, input logic [7:0] f);
        check("last", l, st_last);
        check("next", n, st_next);
        check("queue", q, st_queue);
        check("fill", f, st_fill);
    endtask

    task automatic wait_do(input logic [3:0] exp);
        for (int k = 0; k < 2000 && do_w !== exp; k++) @(negedge clk_sys);
        check("do", {4'h0, exp}, {4'h0, do_w});
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
    endtask

    task automatic t_reset();
        stat(8'h40, 8'hC0, 8'h02, 8'h00);
        check("do", 8'h00, {4'h0, do_w});
        $display("test reset done");
    endtask

    // two entries, end marker on the second, both run out
    task automatic t_exec();
        int b0;
        cfg_wide = 1'b0;
        b0 = n_busy;
        host_u.load(2, 6'h01, 1'b1, 8'h90, ahead(40));
        check("busy", 8'h04, 8'(n_busy - b0));
        stat(8'h42, 8'hC1, 8'h80, 8'h02);
        wait_do(4'h9);
        repeat (3) @(negedge clk_sys);
        stat(8'h42, 8'hC2, 8'h80, 8'h01);
        wait_do(4'h6);
        repeat (3) @(negedge clk_sys);
        stat(8'h42, 8'hC2, 8'h01, 8'h00);
        $display("test exec done");
    endtask

    // sequence 5 where 3 is due: nothing stored
    task automatic t_bad();
        int b0;
        b0 = n_busy;
        host_u.load(1, 6'h05, 1'b1, 8'hF0, ahead(3000));
        check("busy", 8'h03, 8'(n_busy - b0));
        stat(8'h42, 8'hC2, 8'h01, 8'h00);
        $display("test bad sequence done");
    endtask

    // narrow then wide images until the queue refuses
    task automatic t_full();
        int b0;
        do_reset();
        stat(8'h40, 8'hC0, 8'h02, 8'h00);
        check("do", 8'h00, {4'h0, do_w});
        cfg_wide = 1'b0;
        b0 = n_busy;
        host_u.load(6, 6'h01, 1'b0, 8'hF0, ahead(3000));
        check("busy", 8'h07, 8'(n_busy - b0));
        stat(8'h45, 8'hC1, 8'h00, 8'h05);
        cfg_wide = 1'b1;
        // queue state read first: room is left for this image
        check("queue", 8'h00, st_queue);
        b0 = n_busy;
        host_u.load(15, 6'h06, 1'b0, 8'hF0, ahead(3000));
        check("busy", 8'h11, 8'(n_busy - b0));
        stat(8'h54, 8'hC1, 8'h00, 8'h14);
        b0 = n_busy;
        host_u.load(15, 6'h15, 1'b0, 8'hF0, ahead(3000));
        check("busy", 8'h0E, 8'(n_busy - b0));
        stat(8'h5F, 8'hC1, 8'h03, 8'h1F);
        $display("test full done");
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_errors++;
        finish_test();
    end

    initial begin
        do_reset();
        t_reset();
        t_exec();
        t_bad();
        t_full();
        finish_test();
    end
endmodule
